/* hw/coh_port_if.sv */
// Five-channel link between the external master and the coherent slave port.
// Assumes one system clock; both ends sample on the bus clock enable.
`timescale 1ns/100ps
`default_nettype none
interface coh_port_if;
	logic [31:0] aw_addr;
	logic [1:0]  aw_burst;
	logic [3:0]  aw_cache;
	logic [2:0]  aw_id;
	logic [3:0]  aw_len;
	logic [1:0]  write_lock_type;
	logic [2:0]  aw_prot;
	logic [1:0]  aw_size;
	logic [4:0]  write_sideband_attributes;
	logic        aw_valid;
	logic        aw_ready;
	logic [63:0] w_data;
	logic [2:0]  w_id;
	logic        w_last;
	logic [7:0]  write_byte_strobes;
	logic        w_valid;
	logic        w_ready;
	logic [2:0]  b_id;
	logic [1:0]  b_resp;
	logic        b_valid;
	logic        b_ready;
	logic [31:0] ar_addr;
	logic [1:0]  ar_burst;
	logic [3:0]  read_cache_type;
	logic [2:0]  ar_id;
	logic [3:0]  ar_len;
	logic [1:0]  ar_lock;
	logic [2:0]  ar_prot;
	logic [1:0]  ar_size;
	logic [4:0]  read_sideband_attributes;
	logic        ar_valid;
	logic        ar_ready;
	logic [63:0] r_data;
	logic [1:0]  r_resp;
	logic        r_last;
	logic [2:0]  r_id;
	logic        r_valid;
	logic        r_ready;
	modport slave (
		input  aw_addr, aw_burst, aw_cache, aw_id, aw_len, write_lock_type, aw_prot, aw_size,
		input  write_sideband_attributes, aw_valid,
		output aw_ready,
		input  w_data, w_id, w_last, write_byte_strobes, w_valid,
		output w_ready,
		output b_id, b_resp, b_valid,
		input  b_ready,
		input  ar_addr, ar_burst, read_cache_type, ar_id, ar_len, ar_lock, ar_prot, ar_size,
		input  read_sideband_attributes, ar_valid,
		output ar_ready,
		output r_data, r_resp, r_last, r_id, r_valid,
		input  r_ready
	);
	modport master (
		output aw_addr, aw_burst, aw_cache, aw_id, aw_len, write_lock_type, aw_prot, aw_size,
		output write_sideband_attributes, aw_valid,
		input  aw_ready,
		output w_data, w_id, w_last, write_byte_strobes, w_valid,
		input  w_ready,
		input  b_id, b_resp, b_valid,
		output b_ready,
		output ar_addr, ar_burst, read_cache_type, ar_id, ar_len, ar_lock, ar_prot, ar_size,
		output read_sideband_attributes, ar_valid,
		input  ar_ready,
		input  r_data, r_resp, r_last, r_id, r_valid,
		output r_ready
	);
endinterface
`default_nettype wire

/* hw/coh_port_master.sv */
// External master end: runs one read or one write burst per user command.
// Assumes the user holds the command until o_busy drops.
`timescale 1ns/100ps
`default_nettype none
module coh_port_master (
	// Clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst,
	input  wire logic        i_slave_bus_clock_enable,
	// Command
	input  wire logic        i_start,
	input  wire logic        i_write,
	input  wire logic [31:0] i_addr,
	input  wire logic [3:0]  i_len,
	input  wire logic [1:0]  i_size,
	input  wire logic [2:0]  i_id,
	input  wire logic [4:0]  i_attr,
	input  wire logic [3:0]  i_cache,
	input  wire logic        i_exclusive,
	input  wire logic [63:0] i_wdata,
	input  wire logic [7:0]  i_wstrb,
	// Result
	output logic             o_busy,
	output logic             o_rbeat,
	output logic [63:0]      o_rdata,
	output logic [1:0]       o_resp,
	output logic             o_done,
	// Link
	coh_port_if.master       link
);
	typedef enum logic [2:0] {M_IDLE, M_AW, M_W, M_B, M_AR, M_R} mst_state_t;
	mst_state_t  st_reg, st_next;
	logic [3:0]  cnt_reg, cnt_next;
	logic [63:0] rd_reg, rd_next;
	logic [1:0]  resp_reg, resp_next;
	logic        done_reg, done_next, rb_reg, rb_next;
	logic [1:0]  lock;

	assign lock = i_exclusive ? coh_port_pkg::LOCK_EXCLUSIVE : coh_port_pkg::LOCK_NORMAL;

	assign link.aw_addr  = i_addr;
	assign link.aw_burst = coh_port_pkg::BURST_INCR;
	assign link.aw_cache = i_cache;
	assign link.aw_id    = i_id;
	assign link.aw_len   = i_len;
	assign link.write_lock_type = lock;
	assign link.aw_prot  = 3'h0;
	assign link.aw_size  = i_size;
	assign link.write_sideband_attributes = i_attr;
	assign link.aw_valid = (st_reg == M_AW);
	assign link.w_data   = i_wdata;
	assign link.w_id     = i_id;
	assign link.w_last   = (cnt_reg == 4'h0);
	assign link.write_byte_strobes = i_wstrb;
	assign link.w_valid  = (st_reg == M_W);
	assign link.b_ready  = (st_reg == M_B);
	assign link.ar_addr  = i_addr;
	assign link.ar_burst = coh_port_pkg::BURST_INCR;
	assign link.read_cache_type = i_cache;
	assign link.ar_id    = i_id;
	assign link.ar_len   = i_len;
	assign link.ar_lock  = lock;
	assign link.ar_prot  = 3'h0;
	assign link.ar_size  = i_size;
	assign link.read_sideband_attributes = i_attr;
	assign link.ar_valid = (st_reg == M_AR);
	assign link.r_ready  = (st_reg == M_R);

	always_comb begin
		st_next   = st_reg;
		cnt_next  = cnt_reg;
		rd_next   = rd_reg;
		resp_next = resp_reg;
		done_next = 1'b0;
		rb_next   = 1'b0;
		if (i_slave_bus_clock_enable) begin
			case (st_reg)
				M_IDLE: if (i_start) begin
					cnt_next = i_len;
					st_next  = i_write ? M_AW : M_AR;
				end
				M_AW: if (link.aw_ready) st_next = M_W;
				M_W: if (link.w_ready) begin
					cnt_next = cnt_reg - 4'h1;
					if (cnt_reg == 4'h0) st_next = M_B;
				end
				M_B: if (link.b_valid) begin
					resp_next = link.b_resp;
					done_next = 1'b1;
					st_next   = M_IDLE;
				end
				M_AR: if (link.ar_ready) st_next = M_R;
				M_R: if (link.r_valid) begin
					rd_next   = link.r_data;
					resp_next = link.r_resp;
					rb_next   = 1'b1;
					if (link.r_last) begin
						done_next = 1'b1;
						st_next   = M_IDLE;
					end
				end
				default: st_next = M_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			st_reg   <= M_IDLE;
			cnt_reg  <= 4'h0;
			rd_reg   <= coh_port_pkg::DATA_RST;
			resp_reg <= coh_port_pkg::RESP_OKAY;
			done_reg <= 1'b0;
			rb_reg   <= 1'b0;
		end else begin
			st_reg   <= st_next;
			cnt_reg  <= cnt_next;
			rd_reg   <= rd_next;
			resp_reg <= resp_next;
			done_reg <= done_next;
			rb_reg   <= rb_next;
		end
	end

	assign o_busy  = (st_reg != M_IDLE);
	assign o_rbeat = rb_reg;
	assign o_rdata = rd_reg;
	assign o_resp  = resp_reg;
	assign o_done  = done_reg;
endmodule // coh_port_master
`default_nettype wire

/* hw/coh_port_pkg.sv */
// Shared constants and types for the coherent slave port.
// Assumes both ends and the bench compile this first.
package coh_port_pkg;
	localparam int ADDR_W     = 32;
	localparam int DATA_W     = 64;
	localparam int STRB_W     = 8;
	localparam int ID_W       = 3;
	localparam int LEN_W      = 4;
	localparam int SIZE_W     = 2;
	localparam int BURST_W    = 2;
	localparam int LOCK_W     = 2;
	localparam int CACHE_W    = 4;
	localparam int PROT_W     = 3;
	localparam int USER_W     = 5;
	localparam int RESP_W     = 2;
	localparam int MEM_DEPTH  = 256;
	localparam int MEM_AW     = 8;
	// Sideband field positions
	localparam int USER_INNER_HI = 4;
	localparam int USER_INNER_LO = 1;
	localparam int USER_SHARED   = 0;
	// Burst size codes
	localparam logic [1:0] SIZE_8  = 2'h0;
	localparam logic [1:0] SIZE_16 = 2'h1;
	localparam logic [1:0] SIZE_32 = 2'h2;
	localparam logic [1:0] SIZE_64 = 2'h3;
	// Lock codes
	localparam logic [1:0] LOCK_NORMAL    = 2'h0;
	localparam logic [1:0] LOCK_EXCLUSIVE = 2'h1;
	// Burst types
	localparam logic [1:0] BURST_FIXED = 2'h0;
	localparam logic [1:0] BURST_INCR  = 2'h1;
	// Inner attribute codes
	localparam logic [3:0] INNER_SO    = 4'h0;
	localparam logic [3:0] INNER_DEV   = 4'h1;
	localparam logic [3:0] INNER_NC    = 4'h3;
	localparam logic [3:0] INNER_WT    = 4'h6;
	localparam logic [3:0] INNER_WB_NA = 4'h7;
	localparam logic [3:0] INNER_WB_WA = 4'hF;
	// Responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_EXOKAY = 2'h1;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Reset values
	localparam logic [63:0] DATA_RST = 64'h0;
	typedef enum logic [3:0] {
		ATTR_SO, ATTR_DEV, ATTR_NC, ATTR_WT, ATTR_WB_NA, ATTR_WB_WA, ATTR_BAD
	} mem_attr_t;
endpackage

/* hw/coherent_slave_port.sv */
// Device end of the coherent slave port: a small coherent memory behind five channels.
// Assumes the external master keeps its handshake obligations on the link.
// What this block does
// - Write address channel payload, device drives ready.
// - Lock normal b00, exclusive b01; bit1 low.
// - Write data beats with ID, last, valid.
// - 64-bit data, eight strobes, strobed bytes only.
// - Device returns write response, ID, valid.
// - Read address channel payload, device drives ready.
// - Four-bit read length gives number of beats minus one; write bursts end on last.
// - Size codes 8, 16, 32, 64 bit.
// - Write cache type bit 1 gives cacheability; read cache type ignored.
// - Sideband: inner attributes [4:1], shared [0].
// - Decode inner attribute codes to memory types.
// - Device returns read data, response, last, ID.
// - Channels advance only when bus enable high.
`timescale 1ns/100ps
`default_nettype none
module coherent_slave_port (
	// Clock and reset
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst,
	input  wire logic       i_slave_bus_clock_enable,
	// Link
	coh_port_if.slave       link,
	// Status toward the cluster
	output logic [3:0]      o_last_attr,
	output logic            o_last_shared,
	output logic            o_last_cacheable,
	output logic            o_exclusive_seen
);
	typedef enum logic [1:0] {W_ADDR, W_DATA, W_RESP} wr_state_t;
	typedef enum logic [1:0] {R_ADDR, R_DATA} rd_state_t;

	logic [63:0] mem [coh_port_pkg::MEM_DEPTH];

	// -----------------------------------------------------------------
	// Attribute decode
	// -----------------------------------------------------------------
	// inner attribute decode
	function automatic coh_port_pkg::mem_attr_t decode_attr(input logic [3:0] code);
		case (code)
			coh_port_pkg::INNER_SO:    decode_attr = coh_port_pkg::ATTR_SO;
			coh_port_pkg::INNER_DEV:   decode_attr = coh_port_pkg::ATTR_DEV;
			coh_port_pkg::INNER_NC:    decode_attr = coh_port_pkg::ATTR_NC;
			coh_port_pkg::INNER_WT:    decode_attr = coh_port_pkg::ATTR_WT;
			coh_port_pkg::INNER_WB_NA: decode_attr = coh_port_pkg::ATTR_WB_NA;
			coh_port_pkg::INNER_WB_WA: decode_attr = coh_port_pkg::ATTR_WB_WA;
			default:                   decode_attr = coh_port_pkg::ATTR_BAD;
		endcase
	endfunction

	function automatic logic [31:0] size_step(input logic [1:0] size);
		case (size)
			coh_port_pkg::SIZE_8:  size_step = 32'h1;
			coh_port_pkg::SIZE_16: size_step = 32'h2;
			coh_port_pkg::SIZE_32: size_step = 32'h4;
			default:               size_step = 32'h8;
		endcase
	endfunction

	function automatic logic [1:0] access_resp(input logic [4:0] user, input logic [1:0] lock);
		logic [1:0] r;
		r = coh_port_pkg::RESP_OKAY;
		if (decode_attr(user[coh_port_pkg::USER_INNER_HI:coh_port_pkg::USER_INNER_LO])
			== coh_port_pkg::ATTR_BAD) begin
			r = coh_port_pkg::RESP_SLVERR;
		end else if (lock[0] == coh_port_pkg::LOCK_EXCLUSIVE[0]) begin
			r = coh_port_pkg::RESP_EXOKAY;
		end
		access_resp = r;
	endfunction

	// -----------------------------------------------------------------
	// Write path
	// -----------------------------------------------------------------
	wr_state_t   wr_state_reg, wr_state_next;
	logic [31:0] wr_addr_reg, wr_addr_next;
	logic [1:0]  wr_size_reg, wr_size_next;
	logic [1:0]  wr_burst_reg, wr_burst_next;
	logic [2:0]  wr_id_reg, wr_id_next;
	logic [1:0]  wr_resp_reg, wr_resp_next;
	logic        wr_beat;
	logic [coh_port_pkg::MEM_AW-1:0] wr_index;

	assign wr_index = wr_addr_reg[coh_port_pkg::MEM_AW+2:3];
	assign wr_beat = i_slave_bus_clock_enable && link.w_valid && link.w_ready;
	assign link.aw_ready = (wr_state_reg == W_ADDR);
	assign link.w_ready  = (wr_state_reg == W_DATA);
	assign link.b_valid  = (wr_state_reg == W_RESP);
	assign link.b_id     = wr_id_reg;
	assign link.b_resp   = wr_resp_reg;

	always_comb begin
		wr_state_next = wr_state_reg;
		wr_addr_next  = wr_addr_reg;
		wr_size_next  = wr_size_reg;
		wr_burst_next = wr_burst_reg;
		wr_id_next    = wr_id_reg;
		wr_resp_next  = wr_resp_reg;
		if (i_slave_bus_clock_enable) begin
			case (wr_state_reg)
				W_ADDR: begin
					if (link.aw_valid) begin
						wr_addr_next  = link.aw_addr;
						wr_size_next  = link.aw_size;
						wr_burst_next = link.aw_burst;
						wr_id_next    = link.aw_id;
						wr_resp_next  = access_resp(link.write_sideband_attributes,
							link.write_lock_type);
						wr_state_next = W_DATA;
					end
				end
				W_DATA: begin
					if (link.w_valid) begin
						if (wr_burst_reg != coh_port_pkg::BURST_FIXED) begin
							wr_addr_next = wr_addr_reg + size_step(wr_size_reg);
						end
						if (link.w_last) begin
							wr_state_next = W_RESP;
						end
					end
				end
				W_RESP: begin
					if (link.b_ready) begin
						wr_state_next = W_ADDR;
					end
				end
				default: wr_state_next = W_ADDR;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_state_reg <= W_ADDR;
			wr_addr_reg  <= 32'h0;
			wr_size_reg  <= coh_port_pkg::SIZE_64;
			wr_burst_reg <= coh_port_pkg::BURST_INCR;
			wr_id_reg    <= 3'h0;
			wr_resp_reg  <= coh_port_pkg::RESP_OKAY;
		end else begin
			wr_state_reg <= wr_state_next;
			wr_addr_reg  <= wr_addr_next;
			wr_size_reg  <= wr_size_next;
			wr_burst_reg <= wr_burst_next;
			wr_id_reg    <= wr_id_next;
			wr_resp_reg  <= wr_resp_next;
		end
	end

	// byte-lane write mask
	// One writer for the whole array; per-lane processes would each drive all of it
	logic [63:0] lane_mask;
	for (genvar b = 0; b < coh_port_pkg::STRB_W; b++) begin : g_lane
		assign lane_mask[b*8 +: 8] = {8{link.write_byte_strobes[b]}};
	end

	// Errored bursts are still drained but never touch memory
	always_ff @(posedge i_sys_clk) begin
		if (wr_beat && wr_resp_reg != coh_port_pkg::RESP_SLVERR) begin
			mem[wr_index] <= (mem[wr_index] & ~lane_mask) | (link.w_data & lane_mask);
		end
	end

	// -----------------------------------------------------------------
	// Read path
	// -----------------------------------------------------------------
	rd_state_t   rd_state_reg, rd_state_next;
	logic [31:0] rd_addr_reg, rd_addr_next;
	logic [1:0]  rd_size_reg, rd_size_next;
	logic [1:0]  rd_burst_reg, rd_burst_next;
	logic [3:0]  rd_left_reg, rd_left_next;
	logic [2:0]  rd_id_reg, rd_id_next;
	logic [1:0]  rd_resp_reg, rd_resp_next;
	logic [63:0] rd_data_reg, rd_data_next;

	assign link.ar_ready = (rd_state_reg == R_ADDR);
	assign link.r_valid  = (rd_state_reg == R_DATA);
	assign link.r_data   = rd_data_reg;
	assign link.r_resp   = rd_resp_reg;
	assign link.r_id     = rd_id_reg;
	assign link.r_last   = (rd_state_reg == R_DATA) && (rd_left_reg == 4'h0);

	always_comb begin
		logic [31:0] nxt;
		nxt           = rd_addr_reg;
		rd_state_next = rd_state_reg;
		rd_addr_next  = rd_addr_reg;
		rd_size_next  = rd_size_reg;
		rd_burst_next = rd_burst_reg;
		rd_left_next  = rd_left_reg;
		rd_id_next    = rd_id_reg;
		rd_resp_next  = rd_resp_reg;
		rd_data_next  = rd_data_reg;
		if (i_slave_bus_clock_enable) begin
			case (rd_state_reg)
				R_ADDR: begin
					if (link.ar_valid) begin
						rd_addr_next  = link.ar_addr;
						rd_size_next  = link.ar_size;
						rd_burst_next = link.ar_burst;
						rd_left_next  = link.ar_len;
						rd_id_next    = link.ar_id;
						rd_resp_next  = access_resp(link.read_sideband_attributes, link.ar_lock);
						rd_data_next  = mem[link.ar_addr[coh_port_pkg::MEM_AW+2:3]];
						rd_state_next = R_DATA;
					end
				end
				R_DATA: begin
					if (link.r_ready) begin
						if (rd_burst_reg != coh_port_pkg::BURST_FIXED) begin
							nxt = rd_addr_reg + size_step(rd_size_reg);
						end
						rd_addr_next = nxt;
						rd_data_next = mem[nxt[coh_port_pkg::MEM_AW+2:3]];
						rd_left_next = rd_left_reg - 4'h1;
						if (rd_left_reg == 4'h0) begin
							rd_state_next = R_ADDR;
						end
					end
				end
				default: rd_state_next = R_ADDR;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			rd_state_reg <= R_ADDR;
			rd_addr_reg  <= 32'h0;
			rd_size_reg  <= coh_port_pkg::SIZE_64;
			rd_burst_reg <= coh_port_pkg::BURST_INCR;
			rd_left_reg  <= 4'h0;
			rd_id_reg    <= 3'h0;
			rd_resp_reg  <= coh_port_pkg::RESP_OKAY;
			rd_data_reg  <= coh_port_pkg::DATA_RST;
		end else begin
			rd_state_reg <= rd_state_next;
			rd_addr_reg  <= rd_addr_next;
			rd_size_reg  <= rd_size_next;
			rd_burst_reg <= rd_burst_next;
			rd_left_reg  <= rd_left_next;
			rd_id_reg    <= rd_id_next;
			rd_resp_reg  <= rd_resp_next;
			rd_data_reg  <= rd_data_next;
		end
	end

	// -----------------------------------------------------------------
	// Attribute status of the latest accepted write address
	// -----------------------------------------------------------------
	logic [3:0] attr_reg, attr_next;
	logic       shared_reg, shared_next, cach_reg, cach_next, excl_reg, excl_next;

	always_comb begin
		attr_next   = attr_reg;
		shared_next = shared_reg;
		cach_next   = cach_reg;
		excl_next   = excl_reg;
		if (i_slave_bus_clock_enable && link.aw_valid && link.aw_ready) begin
			attr_next   = link.write_sideband_attributes[coh_port_pkg::USER_INNER_HI:
				coh_port_pkg::USER_INNER_LO];
			shared_next = link.write_sideband_attributes[coh_port_pkg::USER_SHARED];
			cach_next   = link.aw_cache[1];
			excl_next   = link.write_lock_type[0];
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			attr_reg   <= 4'h0;
			shared_reg <= 1'b0;
			cach_reg   <= 1'b0;
			excl_reg   <= 1'b0;
		end else begin
			attr_reg   <= attr_next;
			shared_reg <= shared_next;
			cach_reg   <= cach_next;
			excl_reg   <= excl_next;
		end
	end

	assign o_last_attr      = attr_reg;
	assign o_last_shared    = shared_reg;
	assign o_last_cacheable = cach_reg;
	assign o_exclusive_seen = excl_reg;
endmodule // coherent_slave_port
`default_nettype wire

/* verification/coh_port_checker.sv */
// Link checks for the coherent slave port, both ends on one interface.
// Assumes one clock domain; the bench instantiates it beside the interface.
`timescale 1ns/100ps
`default_nettype none
module coh_port_checker (
	// Clock, reset and bus enable
	input wire logic        i_sys_clk,
	input wire logic        i_rst,
	input wire logic        i_slave_bus_clock_enable,
	// Link
	input wire logic [31:0] aw_addr,
	input wire logic        aw_valid,
	input wire logic        aw_ready,
	input wire logic        w_valid,
	input wire logic        w_ready,
	input wire logic        w_last,
	input wire logic [1:0]  b_resp,
	input wire logic [2:0]  b_id,
	input wire logic        b_valid,
	input wire logic        b_ready,
	input wire logic        ar_valid,
	input wire logic        ar_ready,
	input wire logic [63:0] r_data,
	input wire logic        r_last,
	input wire logic        r_valid,
	input wire logic        r_ready
);
	wire logic en;
	assign en = i_slave_bus_clock_enable;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	a_aw_hold: assert property (aw_valid && !(en && aw_ready) |=> aw_valid && $stable(aw_addr))
		else $error("write address dropped before accept");
	a_aw_busy: assert property (en && aw_valid && aw_ready
		|=> !aw_ready && w_ready ##1 !aw_ready)
		else $error("write address not closed or data not opened");
	a_b_after_last: assert property (en && w_valid && w_ready && w_last |=> b_valid && !w_ready)
		else $error("no write response after last beat");
	a_b_hold: assert property (b_valid && !(en && b_ready) |=> b_valid && $stable({b_resp, b_id}))
		else $error("write response changed before accept");
	a_b_done: assert property (en && b_valid && b_ready |=> !b_valid && aw_ready)
		else $error("write channel not reopened");
	a_r_first: assert property (en && ar_valid && ar_ready |=> r_valid && !ar_ready)
		else $error("no read beat after read address");
	a_r_hold: assert property (r_valid && !(en && r_ready) |=> r_valid && $stable({r_data, r_last}))
		else $error("read beat changed before accept");
	a_r_done: assert property (en && r_valid && r_ready && r_last |=> !r_valid && ar_ready)
		else $error("read channel not reopened after last");
	a_en_freeze: assert property (!en |=> $stable({w_ready, b_valid, r_valid, aw_ready}))
		else $error("device moved in a disabled cycle");

	c_write: cover property (en && b_valid && b_ready);
	c_read: cover property (en && r_valid && r_ready && r_last);
	c_stall: cover property (aw_valid && !en);
endmodule // coh_port_checker
`default_nettype wire

/* verification/coherent_axi_slave_port_tb.sv */
// Bench joining the master end and the device end of the coherent slave port.
// Assumes the package and interface are compiled first.
`timescale 1ns/100ps
`default_nettype none
module coherent_axi_slave_port_tb;
	typedef struct packed {
		logic        wr;
		logic [31:0] addr;
		logic [3:0]  len;
		logic [1:0]  size;
		logic [4:0]  attr;
		logic        excl;
		logic [63:0] wdata;
		logic [7:0]  wstrb;
		logic [1:0]  resp;
	} row_t;
	// Second pass of writes repeats the first, so the shadow stays consistent
	localparam row_t ROWS [10] = '{
		'{1'h1, 32'h100, 4'h3, 2'h3, 5'h1F, 1'h0, 64'h1122334455667788, 8'hFF, 2'h0},
		'{1'h0, 32'h100, 4'h3, 2'h3, 5'h1F, 1'h0, 64'h0, 8'h0, 2'h0},
		'{1'h1, 32'h108, 4'h0, 2'h3, 5'h06, 1'h1, 64'hA5A5A5A5A5A5A5A5, 8'h0F, 2'h1},
		'{1'h0, 32'h108, 4'h0, 2'h3, 5'h06, 1'h1, 64'h0, 8'h0, 2'h1},
		'{1'h1, 32'h7F8, 4'h1, 2'h3, 5'h02, 1'h0, 64'hC3C3C3C35A5A5A5A, 8'hFF, 2'h0},
		'{1'h0, 32'h7F8, 4'h1, 2'h3, 5'h02, 1'h0, 64'h0, 8'h0, 2'h0},
		'{1'h1, 32'h100, 4'h0, 2'h3, 5'h04, 1'h0, 64'hDEADDEADDEADDEAD, 8'hFF, 2'h2},
		'{1'h0, 32'h100, 4'h0, 2'h3, 5'h1E, 1'h0, 64'h0, 8'h0, 2'h0},
		'{1'h1, 32'h110, 4'h1, 2'h2, 5'h0D, 1'h0, 64'h0F0F0F0F0F0F0F0F, 8'h0F, 2'h0},
		'{1'h0, 32'h110, 4'h0, 2'h3, 5'h0E, 1'h0, 64'h0, 8'h0, 2'h0}};
	logic        clk, rst, en, start, wr, excl, busy, rbeat, done, last_shared, last_cache;
	logic        excl_seen;
	logic [31:0] addr;
	logic [3:0]  len, cache, last_attr;
	logic [1:0]  size, resp;
	logic [2:0]  id;
	logic [4:0]  attr;
	logic [63:0] wdata, rdata;
	logic [7:0]  wstrb;
	logic [63:0] mem [256];
	row_t        cur;
	int          bad_count, num_checks, cyc, ph, en_mode, wb, rb, tn;

	coh_port_if lk ();
	coherent_slave_port i_coherent_slave_port (.i_sys_clk(clk), .i_rst(rst),
		.i_slave_bus_clock_enable(en), .link(lk), .o_last_attr(last_attr),
		.o_last_shared(last_shared), .o_last_cacheable(last_cache), .o_exclusive_seen(excl_seen));
	coh_port_master i_coh_port_master (.i_sys_clk(clk), .i_rst(rst),
		.i_slave_bus_clock_enable(en), .i_start(start), .i_write(wr), .i_addr(addr),
		.i_len(len), .i_size(size), .i_id(id), .i_attr(attr), .i_cache(cache),
		.i_exclusive(excl), .i_wdata(wdata), .i_wstrb(wstrb), .o_busy(busy), .o_rbeat(rbeat),
		.o_rdata(rdata), .o_resp(resp), .o_done(done), .link(lk));
	coh_port_checker i_coh_port_checker (.i_sys_clk(clk), .i_rst(rst),
		.i_slave_bus_clock_enable(en), .aw_addr(lk.aw_addr), .aw_valid(lk.aw_valid),
		.aw_ready(lk.aw_ready), .w_valid(lk.w_valid), .w_ready(lk.w_ready), .w_last(lk.w_last),
		.b_resp(lk.b_resp), .b_id(lk.b_id), .b_valid(lk.b_valid), .b_ready(lk.b_ready),
		.ar_valid(lk.ar_valid), .ar_ready(lk.ar_ready), .r_data(lk.r_data),
		.r_last(lk.r_last), .r_valid(lk.r_valid), .r_ready(lk.r_ready));

	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk_data(input logic [63:0] g, input logic [63:0] e);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e);
		end
	endtask
	task automatic chk_code(input logic [31:0] g, input logic [31:0] e);
		chk_data({32'h0, g}, {32'h0, e});
	endtask
	function automatic logic [7:0] idx(input row_t r, input int k);
		logic [31:0] a;
		a = r.addr + (k << r.size);
		return a[10:3];
	endfunction
	task automatic load(input row_t r);
		cur = r;
		wr = r.wr;
		addr = r.addr;
		len = r.len;
		size = r.size;
		attr = r.attr;
		excl = r.excl;
		wdata = r.wdata;
		wstrb = r.wstrb;
		id = tn[2:0];
	endtask
	task automatic run(input row_t r);
		int k;
		@(posedge clk);
		#1;
		load(r);
		start = 1'h1;
		k = 0;
		for (int n = 0; n < 400 && done !== 1'h1; n++) begin
			@(posedge clk);
			#1;
			if (busy === 1'h1)
				start = 1'h0;
			if (rbeat === 1'h1) begin
				chk_data(rdata, mem[idx(r, k)]);
				k++;
			end
		end
		chk_code(done, 1'h1);
		chk_code(resp, r.resp);
		if (r.wr) begin
			chk_code({excl_seen, last_cache, last_attr, last_shared}, {r.excl, cache[1], r.attr});
			for (int j = 0; j <= r.len && r.resp != 2'h2; j++)
				for (int b = 0; b < 8; b++)
					if (r.wstrb[b])
						mem[idx(r, j)][8*b +: 8] = r.wdata[8*b +: 8];
		end else
			chk_code(k, r.len + 1);
		$display("test %0d done", tn);
		tn++;
	endtask

	// ------------------------------------------------------------
	// Clock, bus enable and watchdog
	// ------------------------------------------------------------
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		#1;
		ph = (ph + 1) % 3;
		en = (en_mode == 0) || (ph == 0);
		cyc++;
		if (cyc > 20000) begin
			bad_count++;
			stop_test();
		end
	end

	// Wire-level monitor on accepted transfers
	always @(posedge clk) begin
		if (rst) begin
			wb = 0;
			rb = 0;
		end else if (en) begin
			if (lk.aw_valid && lk.aw_ready) begin
				chk_code({lk.aw_len, lk.aw_size, lk.write_lock_type, lk.write_sideband_attributes,
					lk.aw_id, lk.aw_cache}, {cur.len, cur.size, 1'h0, cur.excl, cur.attr, id, cache});
				chk_code(lk.aw_addr, cur.addr);
			end
			if (lk.ar_valid && lk.ar_ready) begin
				chk_code({lk.ar_len, lk.ar_size, lk.ar_lock, lk.read_sideband_attributes, lk.ar_id,
					lk.read_cache_type}, {cur.len, cur.size, 1'h0, cur.excl, cur.attr, id, cache});
				chk_code(lk.ar_addr, cur.addr);
			end
			if (lk.w_valid && lk.w_ready) begin
				wb++;
				chk_code({lk.w_id, lk.w_last, lk.write_byte_strobes}, {id, wb == cur.len + 1, cur.wstrb});
				chk_data(lk.w_data, cur.wdata);
				if (lk.w_last)
					wb = 0;
			end
			if (lk.b_valid && lk.b_ready)
				chk_code(lk.b_id, id);
			if (lk.r_valid && lk.r_ready) begin
				rb++;
				chk_code({lk.r_id, lk.r_last}, {id, rb == cur.len + 1});
				if (lk.r_last)
					rb = 0;
			end
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst = 1'h1;
		cache = 4'hF;
		start = 1'h0;
		load(ROWS[0]);
		repeat (20) @(posedge clk);
		#1;
		rst = 1'h0;
		for (en_mode = 0; en_mode < 2; en_mode++)
			foreach (ROWS[i])
				run(ROWS[i]);
		en_mode = 0;
		// Every inner attribute code, shared and cacheable toggled
		foreach (ROWS[i]) begin
			if (i < 6) begin
				cache = {2'h0, i[0], 1'h0};
				run('{1'h1, 32'h300 + 8 * i, 4'h1, i[1:0], {coh_port_pkg::INNER_SO | 4'(i == 1) |
					4'(i == 2) * coh_port_pkg::INNER_NC | 4'(i == 3) * coh_port_pkg::INNER_WT |
					4'(i == 4) * coh_port_pkg::INNER_WB_NA | 4'(i == 5) * coh_port_pkg::INNER_WB_WA,
					i[0]}, 1'h0, 64'h0123456789ABCDE0 + 64'(i), 8'hFF, 2'h0});
			end
		end
		// Read back the region: a wrong beat step shows as data in an unwritten word
		run('{1'h0, 32'h300, 4'h7, 2'h3, 5'h1F, 1'h0, 64'h0, 8'h0, 2'h0});
		// Reset in the middle of a throttled burst
		cache = 4'hF;
		en_mode = 1;
		load(ROWS[0]);
		start = 1'h1;
		repeat (4) @(posedge clk);
		#1;
		rst = 1'h1;
		start = 1'h0;
		@(posedge clk);
		#1;
		chk_code({busy, lk.aw_valid, lk.w_valid, lk.aw_ready, lk.ar_ready, lk.w_ready, lk.b_valid},
			7'h0C);
		rst = 1'h0;
		$display("test %0d done", tn);
		run(ROWS[0]);
		run(ROWS[1]);
		stop_test();
	end
endmodule // coherent_axi_slave_port_tb
`default_nettype wire
